// ### src/cdag_map.svh
// Constants for the data-address generation block: data-space map, field
// positions, widths and stall counts. Assumes inclusion from SystemVerilog.
`ifndef CDAG_MAP_SVH
`define CDAG_MAP_SVH
`define CDAG_REG_TOP 16'h001F
`define CDAG_IO_TOP 16'h005F
`define CDAG_ISRAM_TOP 16'h015F
`define CDAG_IO_OFFSET 16'h0020
`define CDAG_IMM_BASE 5'h10
`define CDAG_XL 5'h1A
`define CDAG_YL 5'h1C
`define CDAG_ZL 5'h1E
`define CDAG_PC_W 11
`define CDAG_EXT_NOWAIT 3'h1
`define CDAG_EXT_WAIT 3'h2
`define CDAG_ONE16 16'h0001
`define CDAG_ONE11 11'h001
`define CDAG_STALL_ZERO 3'h0
`endif

// ### src/cdag_pkg.sv
// Types for the data-address generation block.
// Assumes cdag_map.svh supplies every numeric constant.
package cdag_pkg;
    // Addressing mode of the current data access
    typedef enum logic [2:0] {
        CDAG_AM_DIRECT = 3'h0,
        CDAG_AM_IO = 3'h1,
        CDAG_AM_IND = 3'h2,
        CDAG_AM_PREDEC = 3'h3,
        CDAG_AM_POSTINC = 3'h4,
        CDAG_AM_DISP = 3'h5
    } cdag_mode_t;
    // Pointer select
    typedef enum logic [1:0] {
        CDAG_PTR_FIRST = 2'h0,
        CDAG_PTR_SECOND = 2'h1,
        CDAG_PTR_THIRD = 2'h2
    } cdag_ptr_t;
    // Program counter source
    typedef enum logic [1:0] {
        CDAG_PC_STEP = 2'h0,
        CDAG_PC_REL = 2'h1,
        CDAG_PC_IND = 2'h2,
        CDAG_PC_HOLD = 2'h3
    } cdag_pcsel_t;
    // Access sequencer states, Gray along idle->access->stall and access->idle
    typedef enum logic [1:0] {
        CDAG_ST_IDLE = 2'h0,
        CDAG_ST_ACCESS = 2'h1,
        CDAG_ST_STALL = 2'h3
    } cdag_state_t;
endpackage

// ### src/cdag_decode.sv
// Data-space region decoder: one registered region per address.
// Assumes a synchronous active-low reset and one clock.
`include "cdag_map.svh"
module cdag_decode
    import cdag_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Address in
    input wire logic [15:0] addr_i,
    // Region out, registered
    output logic is_reg_o,
    output logic is_io_o,
    output logic is_sram_o,
    output logic is_ext_o
);
    typedef struct packed {
        logic r;
        logic io;
        logic s;
        logic e;
    } cdag_dec_t;
    cdag_dec_t q, next_q;
    // Map the four regions of data space (see [RQ5]) (see [RQ6]) (see [RQ2])
    always_comb begin
        next_q = q;
        next_q.r = (addr_i <= `CDAG_REG_TOP);
        next_q.io = (addr_i > `CDAG_REG_TOP) && (addr_i <= `CDAG_IO_TOP);
        next_q.s = (addr_i > `CDAG_IO_TOP) && (addr_i <= `CDAG_ISRAM_TOP);
        next_q.e = (addr_i > `CDAG_ISRAM_TOP);
    end
    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end
    assign is_reg_o = q.r;
    assign is_io_o = q.io;
    assign is_sram_o = q.s;
    assign is_ext_o = q.e;
    // Exactly one region is flagged after a real address
    property p_one_region;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $past(ce_i) && $past(rst_n_i) |-> $onehot({is_reg_o, is_io_o, is_sram_o, is_ext_o});
    endproperty
    a_one_region: assert property (p_one_region) else $error("region flags not one-hot"); // [RQ5]
endmodule

// ### src/cdag_regfile.sv
// 32 x 8 working register file, two read ports and two write ports
// (second port for pointer write-back). Assumes one clock.
`include "cdag_map.svh"
module cdag_regfile
    import cdag_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Read ports
    input wire logic [4:0] ra_i,
    input wire logic [4:0] rb_i,
    output logic [7:0] qa_o,
    output logic [7:0] qb_o,
    // Pointer pair read
    output logic [15:0] x_o,
    output logic [15:0] y_o,
    output logic [15:0] z_o,
    // Write port A, byte
    input wire logic wa_en_i,
    input wire logic [4:0] wa_i,
    input wire logic [7:0] wa_data_i,
    // Write port P, pointer pair (low register index given)
    input wire logic wp_en_i,
    input wire logic [4:0] wp_i,
    input wire logic [15:0] wp_data_i
);
    typedef struct packed {
        logic [31:0][7:0] r;
    } cdag_rf_t;
    cdag_rf_t q, next_q;
    // Per-entry write; pointer write wins over byte write on the same cell
    always_comb begin
        next_q = q;
        for (int i = 0; i < 32; i++) begin
            if (wp_en_i && (5'(i) == wp_i)) begin
                next_q.r[i] = wp_data_i[7:0]; // see [RQ24]
            end else if (wp_en_i && (5'(i) == (wp_i | 5'h01))) begin
                next_q.r[i] = wp_data_i[15:8]; // see [RQ24]
            end else if (wa_en_i && (5'(i) == wa_i)) begin
                next_q.r[i] = wa_data_i;
            end
        end
    end
    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end
    // Combinational reads give single-cycle operand access
    assign qa_o = q.r[ra_i];
    assign qb_o = q.r[rb_i];
    // Pairs R26..R31 form the three pointers (see [RQ3])
    assign x_o = {q.r[`CDAG_XL + 5'h01], q.r[`CDAG_XL]};
    assign y_o = {q.r[`CDAG_YL + 5'h01], q.r[`CDAG_YL]};
    assign z_o = {q.r[`CDAG_ZL + 5'h01], q.r[`CDAG_ZL]};
    // A byte write lands one cycle later
    property p_write_lands;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && wa_en_i && !wp_en_i && (ra_i == wa_i) ##1 (ra_i == $past(wa_i)) |-> qa_o == $past(wa_data_i);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("register write lost"); // [RQ21]
endmodule

// ### src/cdag_core.sv
// Operand address generation, program counter and external-access
// sequencing for the 8-bit core. Assumes instruction fields are already
// decoded by the control unit on the same clock.
`include "cdag_map.svh"
// Functional notes
// [RQ1] Immediate ops reach only registers 16 to 31
// [RQ2] Registers occupy the lowest 32 data addresses
// [RQ3] Registers 26..31 form three pointers
// [RQ4] Eleven-bit program counter over 2048 words
// [RQ5] 96 register/IO, then 256 internal SRAM
// [RQ6] Higher addresses go to external SRAM
// [RQ7] Strobes inactive during internal access
// [RQ8] External access only when enable bit set
// [RQ9] External byte costs one extra cycle
// [RQ10] External stack: calls/returns take two extra
// [RQ11] Wait state: two extra per byte
// [RQ12] IO direct uses six-bit instruction field
// [RQ13] Data direct uses sixteen-bit second word
// [RQ14] Displacement: pointer plus unsigned six bits
// [RQ15] Plain indirect uses pointer unchanged
// [RQ16] Pre-decrement: decrement, use, write back
// [RQ17] Post-increment: use original, then increment
// [RQ18] Constant load: Z word select, bit0 byte
// [RQ19] Indirect jump/call loads PC from Z
// [RQ20] Relative: PC plus offset plus one
// [RQ21] Register ALU op completes in one cycle
// [RQ22] Two-register ops write destination register
// [RQ23] IO seen in data space at plus 20h
// [RQ24] Lower register is pointer low byte
module cdag_core
    import cdag_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Control register bits
    input wire logic external_memory_enable_i,
    input wire logic ext_wait_state_i,
    // Register operation request
    input wire logic alu_en_i,
    input wire logic alu_imm_i,
    input wire logic [4:0] destination_register_i,
    input wire logic [4:0] source_register_i,
    input wire logic [7:0] imm_i,
    input wire logic [1:0] alu_op_i,
    // Data access request
    input wire logic mem_en_i,
    input wire logic mem_write_i,
    input wire cdag_mode_t mode_i,
    input wire cdag_ptr_t ptr_i,
    input wire logic [15:0] direct_addr_i,
    input wire logic [5:0] field6_i,
    input wire logic stack_pc_i,
    // Program counter request
    input wire cdag_pcsel_t pc_sel_i,
    input wire logic [11:0] rel_k_i,
    // Results
    output logic [15:0] data_addr_o,
    output logic [7:0] alu_result_o,
    output logic [10:0] pc_o,
    output logic [10:0] const_word_o,
    output logic const_high_o,
    output logic ext_rd_strobe_o,
    output logic ext_wr_strobe_o,
    output logic busy_o,
    output logic region_reg_o,
    output logic region_io_o,
    output logic region_sram_o,
    output logic region_ext_o
);
    // All state of the sequencer in one struct
    typedef struct packed {
        cdag_state_t st;
        logic [2:0] stall;
        logic [15:0] addr;
        logic [7:0] res;
        logic [10:0] pc;
        logic [10:0] cword;
        logic chigh;
        logic rd;
        logic wr;
        logic wrn;
        logic busy;
    } cdag_core_t;
    cdag_core_t q, next_q;

    // Register file wiring
    logic [7:0] opa;
    logic [7:0] opb;
    logic [15:0] px;
    logic [15:0] py;
    logic [15:0] pz;
    logic [4:0] dst;
    logic [15:0] ptr_val;
    logic [15:0] eff_addr;
    logic [15:0] ptr_new;
    logic ptr_upd;
    logic [4:0] ptr_idx;
    logic [7:0] alu_b;
    logic [7:0] alu_out;
    logic is_ext_addr;
    logic [2:0] ext_cost;
    logic [10:0] pc_rel;
    logic wr_alu;

    // Immediate ops force the top half of the file (see [RQ1])
    assign dst = alu_imm_i ? (destination_register_i | `CDAG_IMM_BASE) : destination_register_i;

    // Pointer select and its low-register index
    always_comb begin
        ptr_val = px;
        ptr_idx = `CDAG_XL;
        case (ptr_i)
            CDAG_PTR_FIRST: begin
                ptr_val = px;
                ptr_idx = `CDAG_XL;
            end
            CDAG_PTR_SECOND: begin
                ptr_val = py;
                ptr_idx = `CDAG_YL;
            end
            CDAG_PTR_THIRD: begin
                ptr_val = pz;
                ptr_idx = `CDAG_ZL;
            end
            default: begin
                ptr_val = px;
                ptr_idx = `CDAG_XL;
            end
        endcase
    end

    // Effective address per addressing mode
    always_comb begin
        eff_addr = ptr_val;
        ptr_new = ptr_val;
        ptr_upd = 1'b0;
        case (mode_i)
            CDAG_AM_DIRECT: eff_addr = direct_addr_i; // see [RQ13]
            // IO ops see 0..3F; data space adds the offset (see [RQ12]) (see [RQ23])
            CDAG_AM_IO: eff_addr = {10'h000, field6_i} + `CDAG_IO_OFFSET;
            CDAG_AM_IND: eff_addr = ptr_val; // see [RQ15]
            CDAG_AM_PREDEC: begin
                // Decrement first, use and store it (see [RQ16])
                ptr_new = ptr_val - `CDAG_ONE16;
                eff_addr = ptr_new;
                ptr_upd = 1'b1;
            end
            CDAG_AM_POSTINC: begin
                // Use old value, store incremented (see [RQ17])
                eff_addr = ptr_val;
                ptr_new = ptr_val + `CDAG_ONE16;
                ptr_upd = 1'b1;
            end
            // Unsigned six-bit displacement (see [RQ14])
            CDAG_AM_DISP: eff_addr = ptr_val + {10'h000, field6_i};
            default: eff_addr = ptr_val;
        endcase
    end

    // Small ALU: operands from destination register and source register or immediate (see [RQ22])
    assign alu_b = alu_imm_i ? imm_i : opb;
    always_comb begin
        case (alu_op_i)
            2'h0: alu_out = opa + alu_b;
            2'h1: alu_out = opa - alu_b;
            2'h2: alu_out = opa & alu_b;
            default: alu_out = opa | alu_b;
        endcase
    end
    assign wr_alu = ce_i && alu_en_i;

    // External region and extra-cycle count
    assign is_ext_addr = eff_addr > `CDAG_ISRAM_TOP;
    assign ext_cost = ext_wait_state_i ? `CDAG_EXT_WAIT : `CDAG_EXT_NOWAIT;
    // Relative branch, wraps within 2K words (see [RQ20])
    assign pc_rel = q.pc + rel_k_i[10:0] + `CDAG_ONE11;

    // Sequencer and program counter next state
    always_comb begin
        next_q = q;
        next_q.rd = 1'b0;
        next_q.wr = 1'b0;
        if (alu_en_i) begin
            next_q.res = alu_out; // see [RQ21]
        end
        case (q.st)
            CDAG_ST_IDLE: begin
                if (mem_en_i) begin
                    next_q.addr = eff_addr;
                    next_q.wrn = mem_write_i;
                    next_q.st = CDAG_ST_ACCESS;
                    // Only enabled external space raises strobes (see [RQ8]) (see [RQ6])
                    if (is_ext_addr && external_memory_enable_i) begin
                        next_q.rd = !mem_write_i;
                        next_q.wr = mem_write_i;
                        // A stacked PC moves two bytes (see [RQ10]) (see [RQ11])
                        next_q.stall = stack_pc_i ? 3'(ext_cost << 1) : ext_cost; // see [RQ9]
                    end else begin
                        next_q.stall = `CDAG_STALL_ZERO; // see [RQ7]
                    end
                end
            end
            CDAG_ST_ACCESS: begin
                if (q.stall != `CDAG_STALL_ZERO) begin
                    next_q.st = CDAG_ST_STALL;
                    next_q.rd = !q.wrn;
                    next_q.wr = q.wrn;
                end else begin
                    next_q.st = CDAG_ST_IDLE;
                end
            end
            CDAG_ST_STALL: begin
                next_q.stall = q.stall - 3'h1;
                if (q.stall == 3'h1) begin
                    next_q.st = CDAG_ST_IDLE;
                end else begin
                    next_q.rd = !q.wrn;
                    next_q.wr = q.wrn;
                end
            end
            default: next_q.st = CDAG_ST_IDLE;
        endcase
        next_q.busy = next_q.st != CDAG_ST_IDLE;
        // Program counter, held while an access stalls
        if (q.st == CDAG_ST_IDLE) begin
            case (pc_sel_i)
                CDAG_PC_STEP: next_q.pc = q.pc + `CDAG_ONE11; // see [RQ4]
                CDAG_PC_REL: next_q.pc = pc_rel; // see [RQ20]
                CDAG_PC_IND: next_q.pc = pz[10:0]; // see [RQ19]
                default: next_q.pc = q.pc;
            endcase
        end
        // Constant load: word from Z[11:1], byte from Z[0] (see [RQ18])
        next_q.cword = pz[11:1];
        next_q.chigh = pz[0];
    end

    // State register
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (ce_i) begin
            q <= next_q;
        end
    end

    // Register file
    cdag_regfile u_rf (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .ra_i(dst),
        .rb_i(source_register_i),
        .qa_o(opa),
        .qb_o(opb),
        .x_o(px),
        .y_o(py),
        .z_o(pz),
        .wa_en_i(wr_alu),
        .wa_i(dst),
        .wa_data_i(alu_out),
        .wp_en_i(ptr_upd && mem_en_i && (q.st == CDAG_ST_IDLE)),
        .wp_i(ptr_idx),
        .wp_data_i(ptr_new)
    );

    // Region decoder, aligned with the registered address
    cdag_decode u_dec (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i && mem_en_i && (q.st == CDAG_ST_IDLE)),
        .addr_i(eff_addr),
        .is_reg_o(region_reg_o),
        .is_io_o(region_io_o),
        .is_sram_o(region_sram_o),
        .is_ext_o(region_ext_o)
    );

    // Outputs straight from flip-flops
    assign data_addr_o = q.addr;
    assign alu_result_o = q.res;
    assign pc_o = q.pc;
    assign const_word_o = q.cword;
    assign const_high_o = q.chigh;
    assign ext_rd_strobe_o = q.rd;
    assign ext_wr_strobe_o = q.wr;
    assign busy_o = q.busy;

    // Internal access never raises a strobe
    property p_int_quiet;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && mem_en_i && (q.st == CDAG_ST_IDLE) && !is_ext_addr
        |=> !ext_rd_strobe_o && !ext_wr_strobe_o;
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal access"); // [RQ7]
    // Disabled external memory never starts a strobe
    property p_ext_gate;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !external_memory_enable_i && q.st == CDAG_ST_IDLE && ce_i |=> !ext_rd_strobe_o && !ext_wr_strobe_o;
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("strobe without enable"); // [RQ8]
    // No-wait external byte: one extra busy cycle
    property p_ext_one;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && mem_en_i && q.st == CDAG_ST_IDLE && is_ext_addr && external_memory_enable_i
        && !ext_wait_state_i && !stack_pc_i ##1 ce_i[*2] |-> busy_o ##1 !busy_o;
    endproperty
    a_ext_one: assert property (p_ext_one) else $error("external byte cost wrong"); // [RQ9]
    // Direct address passes through untouched
    property p_direct;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && mem_en_i && q.st == CDAG_ST_IDLE && mode_i == CDAG_AM_DIRECT |=> data_addr_o == $past(direct_addr_i);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong"); // [RQ13]
    // IO mode lands in 20h..5Fh
    property p_io;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && mem_en_i && q.st == CDAG_ST_IDLE && mode_i == CDAG_AM_IO
        |=> data_addr_o == {10'h000, $past(field6_i)} + 16'h0020;
    endproperty
    a_io: assert property (p_io) else $error("io address wrong"); // [RQ23]
    // Post-increment uses the old pointer
    property p_postinc;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && mem_en_i && q.st == CDAG_ST_IDLE && mode_i == CDAG_AM_POSTINC
        |=> data_addr_o == $past(ptr_val);
    endproperty
    a_postinc: assert property (p_postinc) else $error("post-increment address wrong"); // [RQ17]
    // Indirect jump takes Z
    property p_zjmp;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && q.st == CDAG_ST_IDLE && pc_sel_i == CDAG_PC_IND |=> pc_o == $past(pz[10:0]);
    endproperty
    a_zjmp: assert property (p_zjmp) else $error("indirect jump wrong"); // [RQ19]
    // Relative branch is PC plus k plus one
    property p_rel;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ce_i && q.st == CDAG_ST_IDLE && pc_sel_i == CDAG_PC_REL |=> pc_o == 11'($past(pc_o) + $past(rel_k_i[10:0]) + 11'h001);
    endproperty
    a_rel: assert property (p_rel) else $error("relative branch wrong"); // [RQ20]
endmodule

// ### tb/cdag_ext_sram.sv
// External memory stand-in: measures each strobe burst of the core.
// Assumes the core's clock and active-high strobe levels.
module cdag_ext_sram (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Strobes and address from the core
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    // Last completed burst
    output logic [3:0] last_len_o,
    output logic [15:0] last_addr_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] run;  // Cycles of the burst under way
    // A burst ends on the first cycle with both strobes low
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            run <= 4'h0;
            last_len_o <= 4'h0;
            last_addr_o <= 16'h0000;
        end else if (rd_i || wr_i) begin
            run <= run + 4'h1;
            last_addr_o <= addr_i;
        end else if (run != 4'h0) begin
            last_len_o <= run;
            run <= 4'h0;
        end
    end
endmodule

// ### tb/cpu_data_address_generation_test.sv
// Self-checking bench for the address generation core: corner and random
// operations checked against a register-file and program-counter model.
// Assumes design files and the memory stand-in are compiled first.
`include "cdag_map.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; $display("wrong value t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cpu_data_address_generation_test
    import cdag_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // Design inputs
    logic clk, rst_n, ce, ext_en, ext_wait, alu_en, alu_imm, mem_en, mem_wr, stack_pc;
    logic [4:0] dst, src;
    logic [7:0] imm;
    logic [1:0] alu_op;
    cdag_mode_t mode;
    cdag_ptr_t ptr;
    logic [15:0] daddr;
    logic [5:0] f6;
    cdag_pcsel_t pc_sel;
    logic [11:0] rel_k;
    // Design outputs
    logic [15:0] data_addr, last_addr;
    logic [7:0] alu_res;
    logic [10:0] pc, cword;
    logic chigh, rd, wr, busy, r_reg, r_io, r_sram, r_ext;
    logic [3:0] last_len;
    // Model of the register file and program counter
    logic [7:0] rf [32];
    logic [10:0] pc_m;
    int n_fail = 0;
    int total_checks = 0;
    logic [15:0] corner [8] = '{16'h0000, 16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h015F, 16'h0160, 16'hFFFF};

    cdag_core u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .external_memory_enable_i(ext_en),
        .ext_wait_state_i(ext_wait), .alu_en_i(alu_en), .alu_imm_i(alu_imm), .destination_register_i(dst),
        .source_register_i(src), .imm_i(imm), .alu_op_i(alu_op), .mem_en_i(mem_en), .mem_write_i(mem_wr),
        .mode_i(mode), .ptr_i(ptr), .direct_addr_i(daddr), .field6_i(f6), .stack_pc_i(stack_pc),
        .pc_sel_i(pc_sel), .rel_k_i(rel_k), .data_addr_o(data_addr), .alu_result_o(alu_res), .pc_o(pc),
        .const_word_o(cword), .const_high_o(chigh), .ext_rd_strobe_o(rd), .ext_wr_strobe_o(wr), .busy_o(busy),
        .region_reg_o(r_reg), .region_io_o(r_io), .region_sram_o(r_sram), .region_ext_o(r_ext));
    cdag_ext_sram u_mem (.ref_clk_i(clk), .rst_n_i(rst_n), .rd_i(rd), .wr_i(wr), .addr_i(data_addr),
        .last_len_o(last_len), .last_addr_o(last_addr));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Pointer from its pair, lower register as low byte
    function automatic logic [15:0] ptr_val(input cdag_ptr_t p);
        return {rf[27 + 2 * p], rf[26 + 2 * p]};
    endfunction
    // One-hot region {reg, io, sram, ext}
    function automatic logic [3:0] region(input logic [15:0] a);
        if (a <= `CDAG_REG_TOP) return 4'h8;
        if (a <= `CDAG_IO_TOP) return 4'h4;
        if (a <= `CDAG_ISRAM_TOP) return 4'h2;
        return 4'h1;
    endfunction
    function automatic logic [7:0] alu_f(input logic [1:0] o, input logic [7:0] a, input logic [7:0] b);
        case (o)
            2'h0: return a + b;
            2'h1: return a - b;
            2'h2: return a & b;
            default: return a | b;
        endcase
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Register operation; every task starts and ends 2 ns after an edge
    task automatic alu(input logic i, input logic [4:0] d, input logic [4:0] s, input logic [7:0] k,
                       input logic [1:0] o);
        logic [4:0] dd;
        logic [7:0] e;
        dd = i ? (d | `CDAG_IMM_BASE) : d;
        e = alu_f(o, rf[dd], i ? k : rf[s]);
        alu_en = 1'b1;
        mem_en = 1'b0;
        pc_sel = CDAG_PC_HOLD;
        alu_imm = i;
        dst = d;
        src = s;
        imm = k;
        alu_op = o;
        @(posedge clk);
        #2;
        rf[dd] = e;
        `CHK(alu_res, e)
    endtask

    // Load a pointer pair through clear-then-set immediates
    task automatic set_ptr(input cdag_ptr_t p, input logic [15:0] v);
        alu(1'b1, 5'(26 + 2 * p), 5'h00, 8'h00, 2'h2);
        alu(1'b1, 5'(26 + 2 * p), 5'h00, v[7:0], 2'h3);
        alu(1'b1, 5'(27 + 2 * p), 5'h00, 8'h00, 2'h2);
        alu(1'b1, 5'(27 + 2 * p), 5'h00, v[15:8], 2'h3);
    endtask

    // Data access: address, region, strobes, busy length, pointer update
    task automatic access(input cdag_mode_t m, input cdag_ptr_t p, input logic [15:0] a, input logic [5:0] f,
                          input logic w, input logic st);
        logic [15:0] pv, ea;
        logic ext;
        int exp_len, n;
        pv = ptr_val(p);
        case (m)
            CDAG_AM_DIRECT: ea = a;
            CDAG_AM_IO: ea = {10'h000, f} + `CDAG_IO_OFFSET;
            CDAG_AM_PREDEC: ea = pv - 16'h0001;
            CDAG_AM_DISP: ea = pv + {10'h000, f};
            default: ea = pv;
        endcase
        ext = (region(ea) == 4'h1) && ext_en;
        exp_len = 1 + (ext ? (ext_wait ? 2 : 1) * (st ? 2 : 1) : 0);
        alu_en = 1'b0;
        mem_en = 1'b1;
        pc_sel = CDAG_PC_HOLD;
        mode = m;
        ptr = p;
        daddr = a;
        f6 = f;
        mem_wr = w;
        stack_pc = st;
        @(posedge clk);
        #2;
        mem_en = 1'b0;
        if (m == CDAG_AM_PREDEC) {rf[27 + 2 * p], rf[26 + 2 * p]} = ea;
        if (m == CDAG_AM_POSTINC) {rf[27 + 2 * p], rf[26 + 2 * p]} = pv + 16'h0001;
        `CHK(data_addr, ea)
        `CHK({r_reg, r_io, r_sram, r_ext}, region(ea))
        n = 0;
        while (busy === 1'b1 && n < 8) begin
            n++;
            `CHK({rd, wr}, ext ? (w ? 2'h1 : 2'h2) : 2'h0)
            @(posedge clk);
            #2;
        end
        `CHK(n, exp_len)
        if (ext) begin
            @(posedge clk);
            #2;
            `CHK(last_len, 4'(exp_len))
            `CHK(last_addr, ea)
        end
        pv = ptr_val(CDAG_PTR_THIRD);
        `CHK({cword, chigh}, pv[11:0])
    endtask

    // Program counter request
    task automatic pc_op(input cdag_pcsel_t s, input logic [11:0] k);
        logic [15:0] z;
        z = ptr_val(CDAG_PTR_THIRD);
        alu_en = 1'b0;
        mem_en = 1'b0;
        pc_sel = s;
        rel_k = k;
        @(posedge clk);
        #2;
        case (s)
            CDAG_PC_STEP: pc_m = pc_m + 11'h001;
            CDAG_PC_REL: pc_m = pc_m + k[10:0] + 11'h001;
            CDAG_PC_IND: pc_m = z[10:0];
            default: ;
        endcase
        `CHK(pc, pc_m)
    endtask

    // Main sequence: reset, corners, then random traffic
    initial begin
        {rst_n, ce, ext_en, ext_wait, alu_en, alu_imm, mem_en, mem_wr, stack_pc} = 9'h080;
        {dst, src, imm, alu_op, daddr, f6, rel_k} = '0;
        mode = CDAG_AM_DIRECT;
        ptr = CDAG_PTR_FIRST;
        pc_sel = CDAG_PC_HOLD;
        void'($urandom(32'h9d45));
        foreach (rf[i]) rf[i] = 8'h00;
        pc_m = 11'h000;
        repeat (6) @(posedge clk);
        #2;
        rst_n = 1'b1;
        `CHK(pc, 11'h000)
        foreach (corner[i]) begin
            ext_en = 1'b1;
            ext_wait = i[0];
            access(CDAG_AM_DIRECT, CDAG_PTR_FIRST, corner[i], 6'h3F, i[1], 1'b0);
        end
        for (int j = 0; j < 5; j++) begin
            ext_en = (j != 4);  // Last pass: external place with the enable low
            ext_wait = j[0];
            access(CDAG_AM_IO, CDAG_PTR_FIRST, 16'h0000, 6'(j * 63), 1'b0, 1'b0);
            access(CDAG_AM_DIRECT, CDAG_PTR_FIRST, 16'h8000, 6'h00, j[1], 1'b1);
        end
        // Pointer wrap at both ends
        set_ptr(CDAG_PTR_FIRST, 16'h0000);
        access(CDAG_AM_PREDEC, CDAG_PTR_FIRST, 16'h0000, 6'h00, 1'b0, 1'b0);
        set_ptr(CDAG_PTR_SECOND, 16'hFFFF);
        access(CDAG_AM_POSTINC, CDAG_PTR_SECOND, 16'h0000, 6'h00, 1'b1, 1'b0);
        pc_op(CDAG_PC_STEP, 12'h000);
        pc_op(CDAG_PC_REL, 12'h7FF);
        pc_op(CDAG_PC_REL, 12'h800);
        // Random traffic
        for (int i = 0; i < 400; i++) begin
            ext_en = 1'($urandom);
            ext_wait = 1'($urandom);
            case ($urandom_range(3))
                0: alu(1'($urandom), 5'($urandom), 5'($urandom), 8'($urandom), 2'($urandom));
                1: set_ptr(cdag_ptr_t'($urandom_range(2)), 16'($urandom));
                2: begin
                    mode = cdag_mode_t'($urandom_range(5));
                    ptr = cdag_ptr_t'(mode == CDAG_AM_DISP ? $urandom_range(2, 1) : $urandom_range(2));
                    access(mode, ptr, 16'($urandom), 6'($urandom), 1'($urandom), 1'($urandom));
                end
                default: pc_op(cdag_pcsel_t'($urandom_range(3)), 12'($urandom));
            endcase
        end
        // Clock enable low freezes the counter and the result
        imm = alu_res;
        ce = 1'b0;
        alu_en = 1'b1;
        pc_sel = CDAG_PC_STEP;
        repeat (3) @(posedge clk);
        #2;
        `CHK(pc, pc_m)
        `CHK(alu_res, imm)
        ce = 1'b1;
        alu_en = 1'b0;
        pc_sel = CDAG_PC_HOLD;
        @(posedge clk);
        #2;
        end_of_test();
    end

    // Watchdog, far beyond the expected run length
    initial begin
        #500000;
        n_fail++;
        end_of_test();
    end
endmodule
